// ===== verilog/ssp_regs.svh
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// register indices (word-per-register, byte address = index * 4)
`define SSP_ADDR_BUF 4'h0
`define SSP_ADDR_CTL1 4'h1
`define SSP_ADDR_CTL2 4'h2
`define SSP_ADDR_PERIPHERAL_IRQ_REQUEST_1 4'h3
`define SSP_ADDR_IMASK 4'h4
`define SSP_ADDR_STAT 4'h5
`define SSP_ADDR_DIV 4'h6
// field positions
`define SSP_PERIPHERAL_IRQ_REQUEST_1_BCF 3
`define SSP_CTL1_EN 5
`define SSP_CTL1_MASTER 0
`define SSP_CTL2_CSE 0
`define SSP_CTL2_START 1
`define SSP_CTL2_STOP 2
`define SSP_CTL2_MASTER_RECEIVE_ENABLE 3
// reset values
`define SSP_DIV_RST 8'h31
// timing counts
`define SSP_EXTRA_CLOCKS 4'h9
`define SSP_BITS_PER_BYTE 4'h8
`endif

// ===== verilog/ssp_pkg.sv
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_M_IDLE = 2'b00,
    SSP_M_RECV = 2'b01,
    SSP_M_RUNON = 2'b10,
    SSP_M_EXTRA = 2'b11
  } ssp_mstate_t;
endpackage

// ===== verilog/ssp_i2c_port.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_i2c_port
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // interrupt
  output logic irq,
  // i2c pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // register state
  logic [7:0] buf_q, sr_q, div_q, rdata_q, ctl1_q, ctl2_q, mask_q;
  logic [7:0] pir_q;
  logic master_receive_enable_q;
  logic stretch_q;
  logic [3:0] bit_q;
  logic [3:0] extra_q;
  logic [7:0] cnt_q;
  logic mscl_q;
  ssp_mstate_t ms_q;
  // three-stage pin samplers
  logic [2:0] scl_s, sda_s;
  logic scl_f_q, sda_f_q;

  // pin filtering: a level counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (scl_s[1] == scl_s[2]) scl_f_q <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f_q <= sda_s[2];
    end
  end

  // bus conditions from filtered levels
  logic scl_pd, sda_pd;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      scl_pd <= 1'b1;
      sda_pd <= 1'b1;
    end else begin
      scl_pd <= scl_f_q;
      sda_pd <= sda_f_q;
    end
  end
  wire scl_rise = scl_f_q & ~scl_pd;
  wire start_det = scl_f_q & scl_pd & sda_pd & ~sda_f_q;
  wire stop_det = scl_f_q & scl_pd & ~sda_pd & sda_f_q;

  // decode
  wire en = ctl1_q[`SSP_CTL1_EN];
  wire master = ctl1_q[`SSP_CTL1_MASTER];
  wire cse = ctl2_q[`SSP_CTL2_CSE];
  wire wr_buf = wr && addr == `SSP_ADDR_BUF;
  wire wr_ctl1 = wr && addr == `SSP_ADDR_CTL1;
  wire wr_ctl2 = wr && addr == `SSP_ADDR_CTL2;
  wire wr_pir = wr && addr == `SSP_ADDR_PERIPHERAL_IRQ_REQUEST_1;
  wire rd_buf = rd && addr == `SSP_ADDR_BUF;
  wire dis = wr_ctl1 && !wdata[`SSP_CTL1_EN];
  wire mtick = cnt_q == 8'h00;

  // slave receive: shift on scl rise, byte done after eight bits
  wire slv_act = en && !master;
  wire slv_byte = slv_act && scl_rise && bit_q == (`SSP_BITS_PER_BYTE - 4'h1);
  // master bit clock: toggle of generated scl at each divider tick
  wire m_run = en && master && ms_q != SSP_M_IDLE;
  wire m_rise = m_run && mtick && !mscl_q;
  wire m_byte = ms_q == SSP_M_RECV && m_rise && bit_q == (`SSP_BITS_PER_BYTE - 4'h1);
  wire byte_done = slv_byte || m_byte;
  // the ninth slave clock carries the acknowledge and must not enter the shifter
  wire slv_ack = slv_act && scl_rise && bit_q == `SSP_BITS_PER_BYTE;
  wire shift_en = (slv_act && scl_rise && !slv_ack) || (ms_q == SSP_M_RECV && m_rise);
  wire [7:0] sr_next = {sr_q[6:0], sda_f_q};

  // byte-complete flag: the hardware set wins over a software clear
  wire bcf_set = byte_done;
  wire bcf_clr = wr_pir && wdata[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pir_q <= 8'h00;
    end else if (bcf_set) begin
      pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF] <= 1'b1;
    end else if (bcf_clr) begin
      pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF] <= 1'b0;
    end
  end
  assign irq = |(pir_q & mask_q);

  // shift register and buffer; an unread buffer is overwritten
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sr_q <= 8'h00;
      buf_q <= 8'h00;
      bit_q <= 4'h0;
    end else begin
      if (slv_ack || m_byte) begin
        bit_q <= 4'h0;
      end else if (shift_en) begin
        bit_q <= bit_q + 4'h1;
      end
      if (shift_en) sr_q <= sr_next;
      if (start_det || stop_det || !en) bit_q <= 4'h0;
      if (byte_done) buf_q <= sr_next;
      else if (wr_buf) buf_q <= wdata;
    end
  end

  // clock stretch: hold scl low after a byte until the buffer is read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stretch_q <= 1'b0;
    end else if (slv_byte && cse) begin
      stretch_q <= 1'b1;
    end else if (rd_buf || !slv_act) begin
      // leaving slave mode drops a stale hold so it cannot block a master clock
      stretch_q <= 1'b0;
    end
  end

  // master receive sequencer with the run-on defect kept
  logic master_receive_enable_set;
  assign master_receive_enable_set = wr_ctl2 && wdata[`SSP_CTL2_MASTER_RECEIVE_ENABLE] && en && master;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ms_q <= SSP_M_IDLE;
      master_receive_enable_q <= 1'b0;
      extra_q <= 4'h0;
    end else if (dis) begin
      ms_q <= SSP_M_IDLE;
      master_receive_enable_q <= 1'b0;
    end else begin
      unique case (ms_q)
        SSP_M_IDLE: begin
          if (master_receive_enable_set) begin
            ms_q <= SSP_M_RECV;
            master_receive_enable_q <= 1'b1;
          end
        end
        SSP_M_RECV: begin
          if (stop_det) ms_q <= SSP_M_RUNON;
          else if (m_byte) begin
            ms_q <= SSP_M_IDLE;
            master_receive_enable_q <= 1'b0;
          end
        end
        SSP_M_RUNON: begin
          if (start_det) begin
            ms_q <= SSP_M_EXTRA;
            extra_q <= 4'h0;
          end
        end
        SSP_M_EXTRA: begin
          if (m_rise) extra_q <= extra_q + 4'h1;
          if (m_rise && extra_q == `SSP_EXTRA_CLOCKS - 4'h1) begin
            ms_q <= SSP_M_IDLE;
            master_receive_enable_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // master scl divider
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= `SSP_DIV_RST;
      mscl_q <= 1'b1;
    end else if (!m_run) begin
      cnt_q <= div_q;
      mscl_q <= 1'b1;
    end else if (mtick) begin
      cnt_q <= div_q;
      mscl_q <= ~mscl_q;
    end else begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // control registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctl1_q <= 8'h00;
      ctl2_q <= 8'h00;
      mask_q <= 8'h00;
      div_q <= `SSP_DIV_RST;
    end else begin
      if (wr_ctl1) ctl1_q <= wdata;
      if (wr_ctl2) ctl2_q <= {wdata[7:4], 3'h0, wdata[`SSP_CTL2_CSE]};
      if (wr && addr == `SSP_ADDR_IMASK) mask_q <= wdata;
      if (wr && addr == `SSP_ADDR_DIV) div_q <= wdata;
    end
  end

  // read mux, data one cycle after the strobe
  wire [7:0] ctl2_rd = {ctl2_q[7:4], master_receive_enable_q, 2'h0, ctl2_q[`SSP_CTL2_CSE]};
  wire [7:0] stat_rd = {4'h0, stretch_q, ms_q == SSP_M_RUNON, ms_q};
  wire [7:0] rd_mux = (addr == `SSP_ADDR_BUF) ? buf_q :
                      (addr == `SSP_ADDR_CTL1) ? ctl1_q :
                      (addr == `SSP_ADDR_CTL2) ? ctl2_rd :
                      (addr == `SSP_ADDR_PERIPHERAL_IRQ_REQUEST_1) ? pir_q :
                      (addr == `SSP_ADDR_IMASK) ? mask_q :
                      (addr == `SSP_ADDR_STAT) ? stat_rd :
                      (addr == `SSP_ADDR_DIV) ? div_q : 8'h00;
  always_ff @(posedge clock) begin
    if (!rst_n) rdata_q <= 8'h00;
    else rdata_q <= rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_q;

  // open-drain pins: enable only while pulling low
  assign scl_out = 1'b0;
  assign scl_oe = stretch_q || (m_run && !mscl_q);
  assign sda_out = 1'b0;
  assign sda_oe = 1'b0;

  // assertions
  a_flag_on_byte: assert property (@(posedge clock) disable iff (!rst_n)
    byte_done |=> pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF])
    else $error("byte complete did not set flag");
  a_stretch_holds: assert property (@(posedge clock) disable iff (!rst_n)
    (slv_byte && cse && en) |=> scl_oe until_with (rd_buf || !slv_act))
    else $error("scl released before buffer read");
  a_runon_master_receive_enable: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_RUNON) |-> master_receive_enable_q)
    else $error("receive enable dropped during run-on");
  a_disable_clears: assert property (@(posedge clock) disable iff (!rst_n)
    dis |=> !master_receive_enable_q && ms_q == SSP_M_IDLE)
    else $error("disable did not clear receive enable");
  a_extra_end: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_EXTRA && m_rise && extra_q == (`SSP_EXTRA_CLOCKS - 4'h1) && !dis) |=> !master_receive_enable_q)
    else $error("receive enable not cleared after nine clocks");
  a_buf_capture: assert property (@(posedge clock) disable iff (!rst_n)
    byte_done |=> buf_q == $past(sr_next))
    else $error("buffer not loaded with byte");
  // receive path: the acknowledge clock and idle cycles leave data alone
  a_ack_no_shift: assert property (@(posedge clock) disable iff (!rst_n)
    slv_ack |=> bit_q == 4'h0 && $stable(sr_q))
    else $error("acknowledge clock entered the shifter");
  a_buf_holds: assert property (@(posedge clock) disable iff (!rst_n)
    !(byte_done || wr_buf) |=> $stable(buf_q))
    else $error("buffer changed without a byte");
  a_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (bcf_clr && !bcf_set) |=> !pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF])
    else $error("flag not cleared by write of one");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    (pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF] && !bcf_clr) |=> pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF])
    else $error("flag dropped without a clear");
  a_flag_irq: assert property (@(posedge clock) disable iff (!rst_n)
    (pir_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF] && mask_q[`SSP_PERIPHERAL_IRQ_REQUEST_1_BCF]) |-> irq)
    else $error("unmasked flag without interrupt");
  a_stretch_release: assert property (@(posedge clock) disable iff (!rst_n)
    (stretch_q && rd_buf && !slv_byte) |=> !stretch_q)
    else $error("scl hold kept after buffer read");
  // master sequencer: run-on, extra clocks and disable
  a_runon_clock: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_RUNON && m_run && mtick && !wr_ctl1) |=> scl_oe != $past(scl_oe))
    else $error("scl stopped during run-on");
  a_runon_stays: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_RUNON && !start_det && !dis) |=> ms_q == SSP_M_RUNON)
    else $error("run-on left without a start");
  a_extra_master_receive_enable: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_EXTRA) |-> master_receive_enable_q)
    else $error("receive enable dropped during extra clocks");
  a_idle_no_master_receive_enable: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_IDLE) |-> !master_receive_enable_q)
    else $error("receive enable set while idle");
  a_idle_scl_free: assert property (@(posedge clock) disable iff (!rst_n)
    (ms_q == SSP_M_IDLE && !stretch_q) |-> !scl_oe)
    else $error("scl pulled low while idle");
  a_disable_scl: assert property (@(posedge clock) disable iff (!rst_n)
    dis |=> ##1 !scl_oe)
    else $error("scl still pulled after disable");
endmodule

// ===== tb/ssp_i2c_partner.sv
`timescale 1ns/1ps
// far-side bus device: only pulls lines low, pull-ups give the high level
module ssp_i2c_partner (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // pull-low controls
  output logic scl_lo,
  output logic sda_lo
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  // start: sda falls while scl is high; with own clock scl is then parked low
  task start(input bit own);
    if (!own) @(posedge scl);
    wait (scl);
    #50 sda_lo = 1'b1;
    if (own) #50 scl_lo = 1'b1;
  endtask
  // eight data bits plus a released ack bit; a stretched scl holds us back
  task send(input logic [7:0] b);
    logic [8:0] w;
    w = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      #50 sda_lo = ~w[i];
      #50 scl_lo = 1'b0;
      wait (scl);
      #100 scl_lo = 1'b1;
    end
  endtask
  // stop: sda rises while scl is high
  task stop(input bit own);
    if (!own) @(negedge scl);
    #50 sda_lo = 1'b1;
    #50 scl_lo = 1'b0;
    wait (scl);
    #50 sda_lo = 1'b0;
  endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock;
  logic rst_n;
  logic wr;
  logic rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata, div_v, b;
  logic irq, scl_out, scl_oe, sda_out, sda_oe, scl_lo, sda_lo;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rises = 0;
  int base;
  logic [7:0] rx_q[$];
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h00};
  // open-drain wires with pull-ups: a released line reads high
  wire scl = ~((scl_oe & ~scl_out) | scl_lo);
  wire sda = ~((sda_oe & ~sda_out) | sda_lo);
  ssp_i2c_port uut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  ssp_i2c_partner p (.scl(scl), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // hang guard, far above the few thousand cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      report_and_stop();
    end
  end
  always @(posedge scl) rises++;
  task report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata & m, exp);
  endtask
  task wait_rises(input int n);
    base = rises;
    for (int i = 0; i < 9000 && rises - base < n; i++) @(posedge clock);
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    void'($urandom(47));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, unmapped index 7 included
    for (int i = 0; i < 8; i++) rd_chk(4'(i), rst_tab[i], 8'hff);
    // slave receive with stretching, buffer read while held
    wr_reg(4'h4, 8'h08);
    wr_reg(4'h1, 8'h20);
    wr_reg(4'h2, 8'h01);
    b = 8'($urandom);
    rx_q.push_back(b);
    p.start(1);
    fork
      p.send(b);
    join_none
    repeat (120) @(posedge clock);
    chk({7'h0, scl_oe}, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd_chk(4'h3, 8'h08, 8'h08);
    rd_chk(4'h0, rx_q[$], 8'hff);
    repeat (10) @(posedge clock);
    chk({7'h0, scl_oe}, 8'h00);
    wr_reg(4'h3, 8'h08);
    #1 chk({7'h0, irq}, 8'h00);
    wait fork;
    p.stop(1);
    // no stretching, read late: second byte overwrites the first
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h4, 8'h00);
    p.start(1);
    repeat (2) begin
      b = 8'($urandom);
      rx_q.push_back(b);
      p.send(b);
    end
    p.stop(1);
    chk({7'h0, irq}, 8'h00);
    rd_chk(4'h3, 8'h08, 8'h08);
    rd_chk(4'h0, rx_q[$], 8'hff);
    wr_reg(4'h3, 8'h08);
    // master receive cut by a stop, then a start gives nine more clocks
    div_v = 8'($urandom_range(15, 8));
    wr_reg(4'h6, div_v);
    wr_reg(4'h1, 8'h21);
    // master receive run to its end: eight clocks, flag set, enable clears
    wr_reg(4'h2, 8'h08);
    wait_rises(8);
    repeat (20 * (div_v + 2)) @(posedge clock);
    chk(8'(rises - base), 8'h08);
    rd_chk(4'h2, 8'h00, 8'h08);
    rd_chk(4'h0, 8'hff, 8'hff);
    rd_chk(4'h3, 8'h08, 8'h08);
    wr_reg(4'h3, 8'h08);
    wr_reg(4'h2, 8'h08);
    wait_rises(3);
    p.stop(0);
    wait_rises(20);
    chk(8'(rises - base), 8'd20);
    rd_chk(4'h2, 8'h08, 8'h08);
    p.start(0);
    base = rises;
    repeat (30 * (div_v + 2)) @(posedge clock);
    chk(8'(rises - base), 8'h09);
    rd_chk(4'h2, 8'h00, 8'h08);
    p.sda_lo = 1'b0;
    // stuck receive enable cleared by dropping port enable
    wr_reg(4'h2, 8'h08);
    wait_rises(3);
    p.stop(0);
    wait_rises(5);
    wr_reg(4'h1, 8'h00);
    rd_chk(4'h2, 8'h00, 8'h08);
    base = rises;
    repeat (200) @(posedge clock);
    chk(8'(rises - base), 8'h00);
    report_and_stop();
  end
endmodule
